//--- rtl/nvsc_pkg.sv
// Package of constants for the nonvolatile SRAM host controller.
package nvsc_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam logic [12:0] SEQ_A1 = 13'h0000;
  localparam logic [12:0] SEQ_A2 = 13'h1555;
  localparam logic [12:0] SEQ_A3 = 13'h0AAA;
  localparam logic [12:0] SEQ_A4 = 13'h1FFF;
  localparam logic [12:0] SEQ_A5 = 13'h10F0;
  localparam logic [12:0] SEQ_STORE = 13'h0F0F;
  localparam logic [12:0] SEQ_RECALL = 13'h0F0E;
  localparam int CLK_MHZ = 40;
  localparam int CLK_NS = 25;
  // Strobe phase lengths in ns; a phase is at least one cycle.
  localparam int SETUP_NS = 25;
  localparam int PULSE_NS = 75;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAVE_TIME_MAX_MS = 10;
  localparam int RESTORE_TIME_MAX_US = 20;
  localparam int SAVE_CYC = SAVE_TIME_MAX_MS * 1000 * CLK_MHZ;
  localparam int RESTORE_CYC = RESTORE_TIME_MAX_US * CLK_MHZ;
  localparam int CNT_W = 20;
  typedef enum logic [6:0] {
    NVSC_POWER = 7'h01,
    NVSC_IDLE = 7'h02,
    NVSC_SETUP = 7'h04,
    NVSC_PULSE = 7'h08,
    NVSC_GAP = 7'h10,
    NVSC_BUSY = 7'h20,
    NVSC_DONE = 7'h40
  } nvsc_state_type;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_STORE = 2'h2;
  localparam logic [1:0] OP_RECALL = 2'h3;
endpackage

//--- rtl/nvsc_host.sv
// Host controller that drives the nonvolatile SRAM over its parallel pins.
`timescale 1ns/10ps
module nvsc_host #(
  parameter int SAVE_CYCLES = nvsc_pkg::SAVE_CYC,
  parameter int RESTORE_CYCLES = nvsc_pkg::RESTORE_CYC
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire logic [1:0] req_op_i,
  input wire logic [12:0] req_addr_i,
  input wire logic [7:0] req_wdata_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_rdata_o,
  output logic nv_busy_o,
  output logic [12:0] cell_index_o,
  output logic chip_on_n_o,
  output logic bus_load_n_o,
  output logic drive_out_n_o,
  output logic [7:0] data_pins_o,
  output logic data_pins_oe_o,
  input wire logic [7:0] data_pins_i
);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // The wait counter is shared by every phase, so both times must fit in it.
  if (SAVE_CYCLES < 1 || SAVE_CYCLES >= (1 << nvsc_pkg::CNT_W)) begin : g_bad_save
    $error("SAVE_CYCLES out of range");
  end
  if (RESTORE_CYCLES < 1 || RESTORE_CYCLES >= (1 << nvsc_pkg::CNT_W)) begin : g_bad_restore
    $error("RESTORE_CYCLES out of range");
  end

  // ------------------------------------------------------------
  // Pin input synchroniser
  // ------------------------------------------------------------
  // Data is sampled at the end of the pulse, long after access time, so a
  // three-stage capture with agreement between stages two and three is safe.
  logic [7:0] sync1, sync2, sync3, rd_hold, next_rd_hold;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
      rd_hold <= 8'h00;
    end else begin
      sync1 <= data_pins_i;
      sync2 <= sync1;
      sync3 <= sync2;
      rd_hold <= next_rd_hold;
    end
  end
  always_comb begin
    next_rd_hold = rd_hold;
    if (sync2 == sync3) begin
      next_rd_hold = sync3;
    end
  end

  // ------------------------------------------------------------
  // Access sequencer
  // ------------------------------------------------------------
  nvsc_pkg::nvsc_state_type state, next_state;
  logic [nvsc_pkg::CNT_W-1:0] cnt, next_cnt;
  logic [1:0] op, next_op;
  logic [12:0] addr, next_addr;
  logic [7:0] wdata, next_wdata, rdata, next_rdata;
  logic ce_n, next_ce_n, we_n, next_we_n, oe_n, next_oe_n, doe, next_doe;
  logic ready, next_ready, rsp, next_rsp, busy, next_busy;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_op = op;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_ce_n = ce_n;
    next_we_n = we_n;
    next_oe_n = oe_n;
    next_doe = doe;
    next_ready = 1'b0;
    next_rsp = 1'b0;
    next_busy = busy;
    case (state)
      nvsc_pkg::NVSC_POWER: begin
        // Wait out the automatic recall with every strobe idle.
        if (cnt >= nvsc_pkg::CNT_W'(RESTORE_CYCLES - 1)) begin
          next_state = nvsc_pkg::NVSC_IDLE;
          next_busy = 1'b0;
          next_ready = 1'b1;
          next_cnt = '0;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      nvsc_pkg::NVSC_IDLE: begin
        next_ready = 1'b1;
        if (req_valid_i && ready) begin
          next_ready = 1'b0;
          next_op = req_op_i;
          next_addr = req_addr_i;
          next_wdata = req_wdata_i;
          next_state = nvsc_pkg::NVSC_SETUP;
          next_cnt = '0;
          // Store and recall commands are issued as ordinary reads of the
          // given address; software walks the six steps itself.
          next_doe = (req_op_i == nvsc_pkg::OP_WRITE);
        end
      end
      nvsc_pkg::NVSC_SETUP: begin
        // Address settles with chip enable high before the pulse.
        if (cnt >= nvsc_pkg::CNT_W'(nvsc_pkg::SETUP_CYC - 1)) begin
          next_cnt = '0;
          next_state = nvsc_pkg::NVSC_PULSE;
          next_ce_n = 1'b0;
          if (op == nvsc_pkg::OP_WRITE) begin
            next_we_n = 1'b0;
          end else begin
            next_oe_n = 1'b0;
          end
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      nvsc_pkg::NVSC_PULSE: begin
        if (cnt >= nvsc_pkg::CNT_W'(nvsc_pkg::PULSE_CYC - 1)) begin
          next_cnt = '0;
          // Chip enable and write strobe rise together; data still driven.
          next_ce_n = 1'b1;
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          next_state = nvsc_pkg::NVSC_GAP;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      nvsc_pkg::NVSC_GAP: begin
        // The pin byte needs three stages to settle, so it is taken here, one
        // cycle after the pulse, when the last two stages hold the pulse data.
        next_rdata = next_rd_hold;
        next_doe = 1'b0;
        next_cnt = '0;
        if (op == nvsc_pkg::OP_STORE || op == nvsc_pkg::OP_RECALL) begin
          // After the sixth step the device runs alone; keep hands off.
          next_busy = 1'b1;
          next_state = nvsc_pkg::NVSC_BUSY;
        end else begin
          next_rsp = 1'b1;
          next_state = nvsc_pkg::NVSC_DONE;
        end
      end
      nvsc_pkg::NVSC_BUSY: begin
        // Worst-case store or recall time; a short supply store abort
        // only finishes early, so waiting the full time stays safe.
        if ((op == nvsc_pkg::OP_STORE && cnt >= nvsc_pkg::CNT_W'(SAVE_CYCLES - 1)) ||
            (op == nvsc_pkg::OP_RECALL && cnt >= nvsc_pkg::CNT_W'(RESTORE_CYCLES - 1))) begin
          next_busy = 1'b0;
          next_rsp = 1'b1;
          next_cnt = '0;
          next_state = nvsc_pkg::NVSC_DONE;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      nvsc_pkg::NVSC_DONE: begin
        // One cycle of recovery so steps never run back to back.
        next_ready = 1'b1;
        next_state = nvsc_pkg::NVSC_IDLE;
      end
      default: begin
        next_state = nvsc_pkg::NVSC_IDLE;
        next_ce_n = 1'b1;
        next_we_n = 1'b1;
        next_oe_n = 1'b1;
        next_doe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state <= nvsc_pkg::NVSC_POWER;
      cnt <= '0;
      op <= nvsc_pkg::OP_READ;
      addr <= '0;
      wdata <= 8'h00;
      rdata <= 8'h00;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      doe <= 1'b0;
      ready <= 1'b0;
      rsp <= 1'b0;
      busy <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      op <= next_op;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      ce_n <= next_ce_n;
      we_n <= next_we_n;
      oe_n <= next_oe_n;
      doe <= next_doe;
      ready <= next_ready;
      rsp <= next_rsp;
      busy <= next_busy;
    end
  end

  assign req_ready_o = ready;
  assign rsp_valid_o = rsp;
  assign rsp_rdata_o = rdata;
  assign nv_busy_o = busy;
  assign cell_index_o = addr;
  assign chip_on_n_o = ce_n;
  assign bus_load_n_o = we_n;
  assign drive_out_n_o = oe_n;
  assign data_pins_o = wdata;
  assign data_pins_oe_o = doe;

endmodule // nvsc_host

//--- tb/nvsc_monitor.sv
// Concurrent checks on the pins and handshake of the SRAM host controller.
`timescale 1ns/10ps
// ------
// Checker
// ------
module nvsc_monitor (
  input logic clock_i,
  input logic reset_i,
  input logic req_valid_i,
  input logic [1:0] req_op_i,
  input logic [12:0] req_addr_i,
  input logic req_ready_o,
  input logic rsp_valid_o,
  input logic nv_busy_o,
  input logic [12:0] cell_index_o,
  input logic chip_on_n_o,
  input logic bus_load_n_o,
  input logic drive_out_n_o,
  input logic data_pins_oe_o
);
  logic take;
  assign take = req_valid_i && req_ready_o;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence s_pulse; !chip_on_n_o [*3] ##1 chip_on_n_o; endsequence
  sequence s_no_write; bus_load_n_o [*6]; endsequence
  a_gate_in_write: assert property (
    !bus_load_n_o |-> drive_out_n_o) else $error("Gate low during write.");
  a_addr_held: assert property (
    !chip_on_n_o |-> $stable(cell_index_o)) else $error("Address moved in strobe.");
  a_step_pulse: assert property (
    $fell(chip_on_n_o) |-> s_pulse) else $error("Select pulse not three cycles.");
  a_write_pair: assert property (
    !bus_load_n_o |-> !chip_on_n_o && data_pins_oe_o) else $error("Write strobe alone.");
  a_seq_no_write: assert property (
    take && req_op_i[1] |=> s_no_write) else $error("Write in sequence step.");
  a_access_time: assert property (
    take && !req_op_i[1] |-> ##6 rsp_valid_o) else $error("Access answer late.");
  a_addr_taken: assert property (
    take |=> cell_index_o == $past(req_addr_i)) else $error("Wrong address on pins.");
  a_busy_refuse: assert property (
    nv_busy_o |-> !req_ready_o && bus_load_n_o) else $error("Access while busy.");
endmodule // nvsc_monitor
bind nvsc_host nvsc_monitor i_nvsc_monitor (.*);

//--- tb/nvsc_sram_model.sv
// Behavioural model of the nonvolatile SRAM seen at its pins.
`timescale 1ns/10ps
// ------
// Device model
// ------
module nvsc_sram_model #(
  parameter int SV_NS = 1250,
  parameter int RC_NS = 500
) (
  input wire logic [12:0] cell_index_i,
  input wire logic chip_on_n_i,
  input wire logic bus_load_n_i,
  input wire logic drive_out_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o
);
  localparam logic [12:0] SEQ [5] = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
  logic [7:0] mem [8192];
  logic [7:0] nv [8192];
  logic [7:0] last = 8'h00;
  logic busy = 1'b1;
  logic wseen = 1'b0;
  logic wr, drv;
  int step = 0;
  assign wr = !chip_on_n_i && !bus_load_n_i && !busy;
  assign drv = !chip_on_n_i && !drive_out_n_i && bus_load_n_i && !busy;
  // Released lines show the inverse of the last byte so stale data cannot pass.
  assign data_o = drv ? mem[cell_index_i] : ~last;
  always @* if (drv) last = mem[cell_index_i];
  initial begin
    foreach (nv[i]) nv[i] = 8'h5A ^ i[7:0];
    #RC_NS;
    foreach (mem[i]) mem[i] = nv[i];
    busy = 1'b0;
  end
  always @(negedge wr) mem[cell_index_i] = data_i;
  always @(posedge wr) wseen = 1'b1;
  task automatic nv_cycle(input logic save);
    busy = 1'b1;
    step = 0;
    if (save) begin
      foreach (nv[i]) nv[i] = 8'h00;
      foreach (nv[i]) nv[i] = mem[i];
      #SV_NS;
    end else begin
      foreach (mem[i]) mem[i] = 8'h00;
      #RC_NS;
      foreach (mem[i]) mem[i] = nv[i];
    end
    busy = 1'b0;
  endtask
  // The gate is never looked at here, so steps count with it high or low.
  always @(posedge chip_on_n_i) if (!busy) begin
    if (wseen) step = 0;
    else if (step == 5 && cell_index_i == 13'h0F0F) nv_cycle(1'b1);
    else if (step == 5 && cell_index_i == 13'h0F0E) nv_cycle(1'b0);
    else if (step < 5 && cell_index_i == SEQ[step]) step++;
    else step = int'(cell_index_i == 13'h0000);
    wseen = 1'b0;
  end
endmodule // nvsc_sram_model

//--- tb/nvsc_host_tb_top.sv
// Self-checking testbench of the SRAM host controller with a device model.
`timescale 1ns/10ps
// ------
// Bench
// ------
module nvsc_host_tb_top;
  logic clock_i = 0, reset_i = 1, req_valid_i = 0;
  logic [1:0] req_op_i = 0;
  logic [12:0] req_addr_i = 0, cell_index_o;
  logic [7:0] req_wdata_i = 0, rsp_rdata_o, data_pins_o, data_pins_i, dev_q;
  logic req_ready_o, rsp_valid_o, nv_busy_o, chip_on_n_o, bus_load_n_o;
  logic drive_out_n_o, data_pins_oe_o;
  int failures = 0, n_tests = 0;
  always #12.5 clock_i = ~clock_i;
  assign data_pins_i = data_pins_oe_o ? data_pins_o : dev_q;
  nvsc_host #(.SAVE_CYCLES(50), .RESTORE_CYCLES(20)) i_nvsc_host (.*);
  nvsc_sram_model #(.SV_NS(1250), .RC_NS(500)) i_nvsc_sram_model (.cell_index_i(cell_index_o),
    .chip_on_n_i(chip_on_n_o), .bus_load_n_i(bus_load_n_o), .drive_out_n_i(drive_out_n_o),
    .data_i(data_pins_i), .data_o(dev_q));
  task print_verdict;
    $display("Counts: %0d compared, %0d mismatched", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task req(input logic [1:0] op, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 2000) begin @(negedge clock_i); n++; end
    req_op_i = op; req_addr_i = a; req_wdata_i = d; req_valid_i = 1'b1;
    @(negedge clock_i);
    req_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 2000) begin @(negedge clock_i); n++; end
    if (n >= 2000) begin failures++; print_verdict; end
  endtask
  task seq(input logic [1:0] op, input logic [12:0] a6);
    req(0, 13'h0000, 0); req(0, 13'h1555, 0); req(0, 13'h0AAA, 0);
    req(0, 13'h1FFF, 0); req(0, 13'h10F0, 0); req(op, a6, 0);
  endtask
  task t_rw;
    req(0, 13'h0123, 0); chk("powerup_0123", rsp_rdata_o, 8'h79);
    req(1, 13'h1FFF, 8'hC3); req(1, 13'h0000, 8'h3C);
    req(0, 13'h1FFF, 0); chk("rd_1FFF", rsp_rdata_o, 8'hC3);
    req(0, 13'h0000, 0); chk("rd_0000", rsp_rdata_o, 8'h3C);
    $display("Test rw done.");
  endtask
  task t_store;
    // A leading 0000 read must restart the detector, not spoil the store.
    req(1, 13'h0123, 8'h11); req(0, 13'h0000, 0); seq(2, 13'h0F0F);
    req(1, 13'h0123, 8'h22); seq(3, 13'h0F0E);
    req(0, 13'h0123, 0); chk("recall_0123", rsp_rdata_o, 8'h11);
    $display("Test store done.");
  endtask
  task t_abort;
    req(1, 13'h0123, 8'h33); req(0, 13'h0000, 0); req(0, 13'h1555, 0);
    req(0, 13'h0777, 0); req(0, 13'h0AAA, 0); req(0, 13'h1FFF, 0);
    req(0, 13'h10F0, 0); req(2, 13'h0F0F, 0); seq(3, 13'h0F0E);
    req(0, 13'h0123, 0); chk("abort_0123", rsp_rdata_o, 8'h11);
    $display("Test abort done.");
  endtask
  initial begin
    repeat (6) @(negedge clock_i);
    chk("busy_reset", {7'h00, nv_busy_o}, 8'h01);
    reset_i = 1'b0;
    t_rw;
    t_store;
    t_abort;
    print_verdict;
  end
endmodule // nvsc_host_tb_top
